// [rtl/an_status_regs.sv]
// Decided for this implementation: strobed register access.
`include "an_status_map.svh"
module an_status_regs (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic irq,
	input wire logic page_valid,
	input wire logic [15:0] page_word,
	input wire logic last_tx_toggle,
	input wire logic pd_fault,
	input wire logic partner_negotiates
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic more_pages_wanted;
		logic partner_ack;
		logic message_page_flag;
		logic partner_comply_flag;
		logic toggle_seen;
		logic [10:0] code;
		logic parallel_detect_fault;
		logic partner_extra_pages_capable;
		logic page_received;
		logic partner_negotiates;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic capture_hold;
		logic [15:0] rdata;
		logic irq;
	} state_s;

	state_s r;
	state_s next_r;
	logic rst_n;
	logic pdf_s;
	logic lpan_s;
	logic tog_s;

	reset_sync u_rst (
		.clk(clk),
		.rstn(rstn),
		.rst_n(rst_n)
	);
	// Status levels come from the media side clock, hence synchronised
	sync_bit u_pdf (.clk(clk), .rst_n(rst_n), .d(pd_fault), .q(pdf_s));
	sync_bit u_lpan (.clk(clk), .rst_n(rst_n), .d(partner_negotiates), .q(lpan_s));
	sync_bit u_tog (.clk(clk), .rst_n(rst_n), .d(last_tx_toggle), .q(tog_s));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [15:0] np_word;
		logic [15:0] exp_word;
		logic pdf_rise;
		next_r = r;
		np_word = {r.more_pages_wanted, r.partner_ack, r.message_page_flag,
			r.partner_comply_flag, r.toggle_seen, r.code};
		exp_word = `WORD_ZERO;
		exp_word[`EXP_PDF_BIT] = r.parallel_detect_fault;
		exp_word[`EXP_LP_NP_BIT] = r.partner_extra_pages_capable;
		exp_word[`EXP_NP_BIT] = `LOCAL_EXTRA_PAGES;
		exp_word[`EXP_PAGE_BIT] = r.page_received;
		exp_word[`EXP_LP_AN_BIT] = r.partner_negotiates;
		pdf_rise = pdfs_rise(pdf_s, r.parallel_detect_fault);
		next_r.parallel_detect_fault = pdf_s;
		next_r.partner_negotiates = lpan_s;
		// Page capture; software writes never reach these fields
		if (page_valid && !r.capture_hold) begin
			next_r.more_pages_wanted = page_word[`NP_MORE_BIT];
			next_r.partner_ack = page_word[`NP_ACK_BIT];
			next_r.message_page_flag = page_word[`NP_MSG_BIT];
			next_r.partner_comply_flag = page_word[`NP_COMPLY_BIT];
			next_r.toggle_seen = ~tog_s;
			next_r.code = page_word[10:0];
			next_r.partner_extra_pages_capable = page_word[`NP_MORE_BIT];
		end
		next_r.rdata = `WORD_ZERO;
		if (rd) begin
			if (addr == `ADDR_PARTNER_NEXT_PAGE) begin
				next_r.rdata = np_word;
			end else if (addr == `ADDR_EXPANSION) begin
				next_r.rdata = exp_word;
				next_r.page_received = 1'h0;
			end else if (addr == `ADDR_IRQ_STATUS) begin
				next_r.rdata = {14'h0000, r.irq_status};
			end else if (addr == `ADDR_IRQ_MASK) begin
				next_r.rdata = {14'h0000, r.irq_mask};
			end else if (addr == `ADDR_CAPTURE_CTRL) begin
				next_r.rdata = {15'h0000, r.capture_hold};
			end
		end
		if (wr) begin
			if (addr == `ADDR_IRQ_STATUS) begin
				next_r.irq_status = r.irq_status & ~wdata[1:0];
			end else if (addr == `ADDR_IRQ_MASK) begin
				next_r.irq_mask = wdata[1:0];
			end else if (addr == `ADDR_CAPTURE_CTRL) begin
				next_r.capture_hold = wdata[0];
			end
		end
		// Set wins over clear so no page is lost
		if (page_valid) begin
			next_r.page_received = 1'h1;
			next_r.irq_status[`IRQ_PAGE_BIT] = 1'h1;
		end
		if (pdf_rise) begin
			next_r.irq_status[`IRQ_PDF_BIT] = 1'h1;
		end
		next_r.irq = |(next_r.irq_status & next_r.irq_mask);
	end

	function automatic logic pdfs_rise(input logic now, input logic prev);
		pdfs_rise = now & ~prev;
	endfunction : pdfs_rise

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rdata = r.rdata;
	assign irq = r.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == `ADDR_EXPANSION |=> rdata[15:5] == 11'h000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

	property p_local_extra_pages_capable;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == `ADDR_EXPANSION |=> rdata[`EXP_NP_BIT];
	endproperty
	a_local_extra_pages_capable: assert property (p_local_extra_pages_capable) else $error("local next page bit low");

	property p_page_sets;
		@(posedge clk) disable iff (!rst_n)
		page_valid ##1 rd && addr == `ADDR_EXPANSION |=> rdata[`EXP_PAGE_BIT];
	endproperty
	a_page_sets: assert property (p_page_sets) else $error("page flag lost");

	property p_cor;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == `ADDR_EXPANSION && !page_valid ##1 !page_valid
			##1 rd && addr == `ADDR_EXPANSION |=> !rdata[`EXP_PAGE_BIT];
	endproperty
	a_cor: assert property (p_cor) else $error("page flag not cleared");

	property p_code;
		@(posedge clk) disable iff (!rst_n)
		page_valid && !r.capture_hold ##1 !page_valid && rd && addr == `ADDR_PARTNER_NEXT_PAGE
			|=> rdata[10:0] == $past(page_word[10:0], 2);
	endproperty
	a_code: assert property (p_code) else $error("code field mismatch");

	property p_msg;
		@(posedge clk) disable iff (!rst_n)
		page_valid && !r.capture_hold |=> r.message_page_flag == $past(page_word[13])
			&& r.partner_comply_flag == $past(page_word[12]);
	endproperty
	a_msg: assert property (p_msg) else $error("page flags mismatch");

	property p_more;
		@(posedge clk) disable iff (!rst_n)
		page_valid && !r.capture_hold |=> r.more_pages_wanted == $past(page_word[15]);
	endproperty
	a_more: assert property (p_more) else $error("more pages flag mismatch");

	property p_ack_stable;
		@(posedge clk) disable iff (!rst_n)
		!page_valid |=> $stable(r.partner_ack);
	endproperty
	a_ack_stable: assert property (p_ack_stable) else $error("ack changed without page");

	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		irq |-> (r.irq_status & r.irq_mask) != `IRQ_ZERO;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");

	// ----------------------------------------
	// Field capture, status level and read data checks
	// ----------------------------------------
	property p_ack_capture;
		@(posedge clk) disable iff (!rst_n)
		page_valid && !r.capture_hold |=> r.partner_ack == $past(page_word[`NP_ACK_BIT]);
	endproperty
	a_ack_capture: assert property (p_ack_capture) else $error("ack capture mismatch");

	property p_comply;
		@(posedge clk) disable iff (!rst_n)
		page_valid && !r.capture_hold
			|=> r.partner_comply_flag == $past(page_word[`NP_COMPLY_BIT]);
	endproperty
	a_comply: assert property (p_comply) else $error("comply flag mismatch");

	property p_toggle;
		@(posedge clk) disable iff (!rst_n)
		page_valid && !r.capture_hold |=> r.toggle_seen == !$past(tog_s);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle bit mismatch");

	// Held capture must leave the code field alone
	property p_hold_keeps;
		@(posedge clk) disable iff (!rst_n)
		page_valid && r.capture_hold |=> $stable(r.code);
	endproperty
	a_hold_keeps: assert property (p_hold_keeps) else $error("held code changed");

	property p_pdf_follow;
		@(posedge clk) disable iff (!rst_n)
		1'h1 |=> r.parallel_detect_fault == $past(pdf_s);
	endproperty
	a_pdf_follow: assert property (p_pdf_follow) else $error("fault level mismatch");

	property p_lp_np;
		@(posedge clk) disable iff (!rst_n)
		page_valid && !r.capture_hold
			|=> r.partner_extra_pages_capable == $past(page_word[`NP_MORE_BIT]);
	endproperty
	a_lp_np: assert property (p_lp_np) else $error("partner page ability mismatch");

	// The page flag is only lost through a read of the expansion word
	property p_page_hold;
		@(posedge clk) disable iff (!rst_n)
		r.page_received && !(rd && addr == `ADDR_EXPANSION) |=> r.page_received;
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("page flag dropped");

	property p_lpan_follow;
		@(posedge clk) disable iff (!rst_n)
		1'h1 |=> r.partner_negotiates == $past(lpan_s);
	endproperty
	a_lpan_follow: assert property (p_lpan_follow) else $error("negotiate level mismatch");

	property p_np_addr;
		@(posedge clk) disable iff (!rst_n)
		rd && addr == `ADDR_PARTNER_NEXT_PAGE && !page_valid
			|=> rdata[`NP_MSG_BIT] == r.message_page_flag;
	endproperty
	a_np_addr: assert property (p_np_addr) else $error("next page word misplaced");

	// Read data must not linger past their one cycle
	property p_rdata_idle;
		@(posedge clk) disable iff (!rst_n)
		!rd |=> rdata == `WORD_ZERO;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	c_same_cycle: cover property (@(posedge clk) page_valid && rd && addr == `ADDR_EXPANSION);
	c_hold_page: cover property (@(posedge clk) page_valid && r.capture_hold);
	c_page_read: cover property (@(posedge clk) page_valid ##2 rd && addr == `ADDR_EXPANSION);
	c_np_read: cover property (@(posedge clk) rd && addr == `ADDR_PARTNER_NEXT_PAGE);
	c_irq: cover property (@(posedge clk) irq);
endmodule : an_status_regs

// [common/an_status_map.svh]
`ifndef AN_STATUS_MAP_SVH
`define AN_STATUS_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_PARTNER_NEXT_PAGE 5'h05
`define ADDR_EXPANSION 5'h06
`define ADDR_IRQ_STATUS 5'h10
`define ADDR_IRQ_MASK 5'h11
`define ADDR_CAPTURE_CTRL 5'h12
// ----------------------------------------
// Field positions
// ----------------------------------------
`define NP_MORE_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_BIT 13
`define NP_COMPLY_BIT 12
`define NP_TOGGLE_BIT 11
`define EXP_PDF_BIT 4
`define EXP_LP_NP_BIT 3
`define EXP_NP_BIT 2
`define EXP_PAGE_BIT 1
`define EXP_LP_AN_BIT 0
`define IRQ_PAGE_BIT 0
`define IRQ_PDF_BIT 1
// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define WORD_ZERO 16'h0000
`define CODE_ZERO 11'h000
`define IRQ_ZERO 2'h0
`define LOCAL_EXTRA_PAGES 1'h1
`endif

// [common/an_status_pkg.sv]
package an_status_pkg;
	typedef logic [15:0] word_t;
	typedef logic [4:0] addr_t;
endpackage : an_status_pkg

// [rtl/sync_bit.sv]
module sync_bit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic [1:0] stage;
	// Only the second stage is visible outside
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage <= 2'h0;
		end else begin
			stage <= {stage[0], d};
		end
	end
	assign q = stage[1];
endmodule : sync_bit

// [rtl/reset_sync.sv]
module reset_sync (
	input wire logic clk,
	input wire logic rstn,
	output logic rst_n
);
	logic [1:0] stage;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage <= 2'h0;
		end else begin
			stage <= {stage[0], 1'h1};
		end
	end
	assign rst_n = stage[1];
endmodule : reset_sync

// [testbench/far_negotiator.sv]
module far_negotiator (
	input wire logic clk,
	output logic page_valid,
	output logic [15:0] page_word,
	output logic last_tx_toggle,
	output logic pd_fault,
	output logic partner_negotiates
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		page_valid = 1'h0;
		page_word = 16'h0000;
		last_tx_toggle = 1'h0;
		pd_fault = 1'h0;
		partner_negotiates = 1'h0;
	end
	// Word is inverted once the pulse ends, so a stale value is never mistaken for a page
	task send(input logic [15:0] w);
		@(posedge clk);
		page_valid <= 1'h1;
		page_word <= w;
		@(posedge clk);
		page_valid <= 1'h0;
		page_word <= ~w;
	endtask : send
	task levels(input logic t, input logic f, input logic n);
		@(posedge clk);
		last_tx_toggle <= t;
		pd_fault <= f;
		partner_negotiates <= n;
		repeat (4) @(posedge clk);
	endtask : levels
endmodule : far_negotiator

// [testbench/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	an_status_pkg::addr_t addr = 5'h00;
	an_status_pkg::word_t wdata = 16'h0000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [15:0] rdata;
	logic irq;
	logic page_valid;
	logic [15:0] page_word;
	logic last_tx_toggle;
	logic pd_fault;
	logic partner_negotiates;
	int fails = 0;
	int comparisons = 0;
	initial forever #2 clk = ~clk;
	an_status_regs i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .page_valid(page_valid), .page_word(page_word),
		.last_tx_toggle(last_tx_toggle), .pd_fault(pd_fault),
		.partner_negotiates(partner_negotiates));
	far_negotiator i_far (.clk(clk), .page_valid(page_valid), .page_word(page_word),
		.last_tx_toggle(last_tx_toggle), .pd_fault(pd_fault),
		.partner_negotiates(partner_negotiates));
	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task report_and_stop;
		if (fails == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input an_status_pkg::addr_t a, input an_status_pkg::word_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task rd_chk(input an_status_pkg::addr_t a, input an_status_pkg::word_t exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(rdata, exp);
	endtask : rd_chk
	task irq_chk(input logic exp);
		repeat (2) @(posedge clk);
		#1 chk({15'h0000, irq}, {15'h0000, exp});
	endtask : irq_chk
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		rd_chk(5'h05, 16'h0000);
		rd_chk(5'h06, 16'h0004);
		rd_chk(5'h11, 16'h0000);
		rd_chk(5'h1F, 16'h0000);
	endtask : t_reset
	task t_page;
		i_far.levels(1'h0, 1'h1, 1'h1);
		i_far.send(16'hF7FF);
		rd_chk(5'h05, 16'hFFFF);
		rd_chk(5'h06, 16'h001F);
		rd_chk(5'h06, 16'h001D);
		wr_reg(5'h06, 16'hFFFF);
		wr_reg(5'h05, 16'h0000);
		rd_chk(5'h05, 16'hFFFF);
		rd_chk(5'h06, 16'h001D);
		i_far.levels(1'h1, 1'h0, 1'h0);
		i_far.send(16'h2555);
		rd_chk(5'h05, 16'h2555);
		rd_chk(5'h06, 16'h0006);
		rd_chk(5'h06, 16'h0004);
	endtask : t_page
	task t_same_cycle;
		fork
			i_far.send(16'h8000);
			rd_chk(5'h06, 16'h0004);
		join
		rd_chk(5'h06, 16'h000E);
		rd_chk(5'h05, 16'h8000);
	endtask : t_same_cycle
	task t_irq;
		wr_reg(5'h11, 16'h0001);
		irq_chk(1'h1);
		wr_reg(5'h10, 16'h0003);
		rd_chk(5'h10, 16'h0000);
		irq_chk(1'h0);
		wr_reg(5'h12, 16'h0001);
		i_far.send(16'h0123);
		irq_chk(1'h1);
		rd_chk(5'h05, 16'h8000);
		wr_reg(5'h11, 16'h0000);
		irq_chk(1'h0);
		wr_reg(5'h12, 16'h0000);
	endtask : t_irq
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		repeat (3) @(posedge clk);
		t_reset();
		t_page();
		t_same_cycle();
		t_irq();
		report_and_stop();
	end
	// Guard against a hung bus sequence
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule : tb
